// file: seb_pkg.sv
package seb_pkg;
	localparam logic [7:0] CMD_EN_MOD = 8'h06;
	localparam logic [7:0] CMD_DIS_MOD = 8'h04;
	localparam logic [7:0] CMD_RD_FLAGS = 8'h05;
	localparam logic [7:0] CMD_WR_FLAGS = 8'h01;
	localparam logic [7:0] CMD_RD_ARR = 8'h03;
	localparam logic [7:0] CMD_WR_ARR = 8'h02;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int PAGE_BITS = 7;
	localparam int FIFO_DEPTH = 16;
	localparam int FLG_BUSY = 0;
	localparam int FLG_WEL = 1;
	localparam int FLG_BP_LO = 2;
	localparam int FLG_BP_HI = 3;
	localparam logic [15:0] PROT_QTR = 16'hc000;
	localparam logic [15:0] PROT_HALF = 16'h8000;
	localparam int CLK_PERIOD_NS = 8;
	localparam int T_WRITE_NS = 5_000_000;
	localparam int WRITE_CYCLES = T_WRITE_NS / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		PH_CMD = 2'b00,
		PH_ADDR = 2'b01,
		PH_DATA = 2'b11,
		PH_IGN = 2'b10
	} seb_phase_t;
	typedef struct packed {
		logic sck;
		logic cs_n;
		logic mosi;
		logic hold_n;
		logic wp_n;
	} seb_pins_t;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} seb_wr_t;
	typedef struct packed {
		logic armed, held, alig, ahi, got, drv;
		seb_phase_t ph;
		logic [2:0] bitn;
		logic [7:0] cmd, sh, tx, wdata;
		logic [15:0] addr, maddr;
		logic miso, oe_n, wel, rd, rdw, we, pend;
		logic commit, abort, busy, stby, ovr;
		logic [1:0] bp;
	} seb_state_t;
	localparam seb_state_t ST_RST = '{ph: PH_CMD, oe_n: 1'b1, default: '0};
endpackage

// file: seb_core.sv
`timescale 1ns/10ps
module seb_fifo #(
	parameter int W = 24,
	parameter int D = 16
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         flush_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_r [D];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;
	assign in_ready_o = cnt_r != (AW+1)'(D);
	assign out_valid_o = cnt_r != '0;
	assign out_data_o = mem_r[rp_r];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	always_comb
	begin
		wp_nxt = flush_i ? '0 : wp_r + AW'(push);
		rp_nxt = flush_i ? '0 : rp_r + AW'(pop);
		cnt_nxt = flush_i ? '0 : cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
		if (push)
			mem_r[wp_r] <= in_data_i;
	end
endmodule

// What this block does
// - output bit changes on clock falling edge
// - input bits captured on clock rising edge
// - output undriven while select is high
// - standby when deselected and not writing
// - ignore everything until first select fall
// - pause: output off, clock ignored, position kept
// - protect input freezes protect range bits
// - all inbound fields most significant first
// - first bit on first rise after select
// - outbound bytes most significant bit first
// - read data starts first fall after address
// - serve mode 0 and mode 3 alike
// - array is 65536 bytes, linear address
// - write bursts wrap inside 128-byte page
// - programming finishes within write time
// - six eight-bit instruction codes
// - unknown code: ignore rest of transaction
// - pause enters and leaves with clock low
// - modify runs only on aligned deselect
module seb_core
	import seb_pkg::*;
#(
	parameter int WRITE_CYC = WRITE_CYCLES
) (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               sck_i,
	input  wire logic               cs_n_i,
	input  wire logic               mosi_i,
	input  wire logic               hold_n_i,
	input  wire logic               wp_n_i,
	output logic                    miso_o,
	output logic                    miso_oe_n_o,
	output logic [ADDR_W-1:0]       mem_addr_o,
	output logic                    mem_rd_o,
	input  wire logic [DATA_W-1:0]  mem_rdata_i,
	output logic                    mem_we_o,
	output logic [DATA_W-1:0]       mem_wdata_o,
	input  wire logic               mem_wr_ready_i,
	output logic                    mem_commit_o,
	output logic                    mem_abort_o,
	output logic                    busy_o,
	output logic                    wel_o,
	output logic [1:0]              bp_o,
	output logic                    standby_o,
	output logic                    overrun_o
);
	seb_pins_t pin, s1_r, s2_r, pv_r;
	seb_state_t s, n;
	logic [31:0] tmr_r, tmr_nxt;
	logic sel, rise_e, fall_e, cs_rise, cs_fall, outp;
	logic push_v, f_rdy, f_val, f_pop;
	logic [7:0] byte_in;
	seb_wr_t push_d, f_out;

	function automatic logic [7:0] flags(input seb_state_t x);
		logic [7:0] f;
		f = '0;
		f[FLG_BUSY] = x.busy;
		f[FLG_WEL] = x.wel;
		f[FLG_BP_HI:FLG_BP_LO] = x.bp;
		return f;
	endfunction

	function automatic logic prot(input logic [15:0] a, input logic [1:0] bp);
		return (bp == 2'b11) | (bp == 2'b01 && a >= PROT_QTR)
			| (bp == 2'b10 && a >= PROT_HALF);
	endfunction

	function automatic logic known(input logic [7:0] c);
		return c == CMD_EN_MOD || c == CMD_DIS_MOD || c == CMD_RD_FLAGS
			|| c == CMD_WR_FLAGS || c == CMD_RD_ARR || c == CMD_WR_ARR;
	endfunction

	assign pin = '{sck: sck_i, cs_n: cs_n_i, mosi: mosi_i,
		hold_n: hold_n_i, wp_n: wp_n_i};

	// pins are asynchronous; sclk is sampled and read data loads three cycles after a rise, so it needs at most clk_i/6
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			// select resets low: only a high really seen on the pin can arm
			s1_r <= '{cs_n: 1'b0, hold_n: 1'b1, wp_n: 1'b1, default: '0};
			s2_r <= '{cs_n: 1'b0, hold_n: 1'b1, wp_n: 1'b1, default: '0};
			pv_r <= '{cs_n: 1'b0, hold_n: 1'b1, wp_n: 1'b1, default: '0};
		end
		else
		begin
			s1_r <= pin;
			s2_r <= s1_r;
			pv_r <= s2_r;
		end
	end

	assign cs_fall = pv_r.cs_n & ~s2_r.cs_n;
	assign cs_rise = ~pv_r.cs_n & s2_r.cs_n;
	assign sel = ~s2_r.cs_n & s.armed;
	// edges are found the same way whatever the idle level
	assign rise_e = sel & ~s.held & s2_r.sck & ~pv_r.sck;
	assign fall_e = sel & ~s.held & ~s2_r.sck & pv_r.sck;
	assign byte_in = {s.sh[6:0], s2_r.mosi};
	assign outp = s.ph == PH_DATA && (s.cmd == CMD_RD_ARR || s.cmd == CMD_RD_FLAGS);
	assign f_pop = f_val & (~s.we | mem_wr_ready_i);

	seb_fifo #(
		.W($bits(seb_wr_t)),
		.D(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.flush_i(s.abort),
		.in_valid_i(push_v),
		.in_ready_o(f_rdy),
		.in_data_i(push_d),
		.out_valid_o(f_val),
		.out_ready_i(f_pop),
		.out_data_o(f_out)
	);

	always_comb
	begin
		n = s;
		push_v = 1'b0;
		push_d = '0;
		n.rd = 1'b0;
		n.commit = 1'b0;
		n.abort = 1'b0;
		n.rdw = s.rd;
		if (cs_fall)
		begin
			n.armed = 1'b1;
			// cleared first so a byte lost in the same cycle still shows
			n.ovr = 1'b0;
		end
		// level test covers a pause edge that lands with sclk high
		n.held = s2_r.cs_n ? 1'b0 : (s2_r.sck ? s.held : ~s2_r.hold_n);
		if (rise_e)
		begin
			n.sh = byte_in;
			n.bitn = s.bitn + 3'd1;
			n.alig = 1'b0;
			if (s.bitn == 3'd7)
			begin
				n.alig = 1'b1;
				unique case (s.ph)
					PH_CMD:
					begin
						n.cmd = byte_in;
						if (!known(byte_in) || (s.busy && byte_in != CMD_RD_FLAGS))
							n.ph = PH_IGN;
						else if (byte_in == CMD_RD_ARR || byte_in == CMD_WR_ARR)
							n.ph = PH_ADDR;
						else
							n.ph = PH_DATA;
						n.tx = flags(s);
					end
					PH_ADDR:
					begin
						n.addr = {s.addr[7:0], byte_in};
						n.ahi = ~s.ahi;
						if (s.ahi)
						begin
							n.ph = PH_DATA;
							n.rd = s.cmd == CMD_RD_ARR;
							n.maddr = {s.addr[7:0], byte_in};
						end
					end
					PH_DATA:
					begin
						n.got = 1'b1;
						if (s.cmd == CMD_RD_ARR)
						begin
							n.addr = s.addr + 16'h0001;
							n.maddr = s.addr + 16'h0001;
							n.rd = 1'b1;
						end
						else if (s.cmd == CMD_RD_FLAGS)
							n.tx = flags(s);
						else if (s.cmd == CMD_WR_ARR)
						begin
							push_v = 1'b1;
							push_d = '{addr: s.addr, data: byte_in};
							n.addr[PAGE_BITS-1:0] = s.addr[PAGE_BITS-1:0] + 7'h01;
							n.ovr = n.ovr | ~f_rdy;
						end
					end
					PH_IGN:
					begin
					end
				endcase
			end
		end
		if (fall_e && outp)
		begin
			n.miso = s.tx[7];
			n.tx = {s.tx[6:0], 1'b0};
			n.drv = 1'b1;
		end
		if (s.rdw)
			n.tx = mem_rdata_i;
		if (cs_rise)
		begin
			// a clock rise after the last full byte voids the modify
			if (s.armed && s.alig && s.ph == PH_DATA)
			begin
				if (s.cmd == CMD_EN_MOD && !s.got)
					n.wel = 1'b1;
				if (s.cmd == CMD_DIS_MOD && !s.got)
					n.wel = 1'b0;
				if (s.cmd == CMD_WR_FLAGS && s.got && s.wel)
				begin
					n.wel = 1'b0;
					if (s2_r.wp_n)
						n.bp = s.sh[FLG_BP_HI:FLG_BP_LO];
				end
				if (s.cmd == CMD_WR_ARR && s.got && s.wel)
				begin
					n.wel = 1'b0;
					n.pend = 1'b1;
					n.busy = 1'b1;
				end
			end
			if (s.cmd == CMD_WR_ARR && !n.pend)
				n.abort = 1'b1;
			n.ph = PH_CMD;
			n.bitn = '0;
			n.ahi = 1'b0;
			n.got = 1'b0;
			n.drv = 1'b0;
			n.alig = 1'b0;
			n.cmd = '0;
		end
		n.oe_n = ~(sel & n.drv & ~n.held);
		// bytes stream to the page latch; commit waits for the drain
		if (s.we && mem_wr_ready_i)
			n.we = 1'b0;
		if (f_pop)
		begin
			n.we = ~prot(f_out.addr, s.bp);
			n.wdata = f_out.data;
			n.maddr = f_out.addr;
		end
		if (s.pend && !f_val && !s.we)
		begin
			n.pend = 1'b0;
			n.commit = 1'b1;
		end
		if (s.busy && !s.pend && tmr_r == 32'd1)
			n.busy = 1'b0;
		n.stby = s2_r.cs_n & ~n.busy;
	end

	always_comb
	begin
		if (s.commit)
			tmr_nxt = 32'(WRITE_CYC) - 32'd1;
		else if (tmr_r != '0)
			tmr_nxt = tmr_r - 32'd1;
		else
			tmr_nxt = '0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s <= ST_RST;
			tmr_r <= '0;
		end
		else
		begin
			s <= n;
			tmr_r <= tmr_nxt;
		end
	end

	assign miso_o = s.miso;
	assign miso_oe_n_o = s.oe_n;
	// no id page in this build; every address maps to the main array
	assign mem_addr_o = s.maddr;
	assign mem_rd_o = s.rd;
	assign mem_we_o = s.we;
	assign mem_wdata_o = s.wdata;
	assign mem_commit_o = s.commit;
	assign mem_abort_o = s.abort;
	assign busy_o = s.busy;
	assign wel_o = s.wel;
	assign bp_o = s.bp;
	assign standby_o = s.stby;
	assign overrun_o = s.ovr;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_cmd_byte;
		rise_e && s.ph == PH_CMD && s.bitn == 3'd7;
	endsequence
	sequence s_addr_done;
		rise_e && s.ph == PH_ADDR && s.ahi && s.bitn == 3'd7 && s.cmd == CMD_RD_ARR;
	endsequence

	property p_desel;
		s2_r.cs_n |=> miso_oe_n_o;
	endproperty
	a_desel: assert property (p_desel)
		else $error("output driven while deselected");
	property p_hold_off;
		s.held && !s2_r.hold_n |=> miso_oe_n_o;
	endproperty
	a_hold_off: assert property (p_hold_off)
		else $error("output driven during pause");
	property p_hold_keep;
		s.held && !s2_r.cs_n |=> $stable(s.bitn) && $stable(s.sh);
	endproperty
	a_hold_keep: assert property (p_hold_keep)
		else $error("shift position moved during pause");
	property p_unarmed;
		!s.armed |-> s.ph == PH_CMD && s.bitn == 3'd0 && s.oe_n;
	endproperty
	a_unarmed: assert property (p_unarmed)
		else $error("activity before first select fall");
	property p_msb;
		rise_e |=> s.sh[0] == $past(s2_r.mosi) && s.sh[7:1] == $past(s.sh[6:0]);
	endproperty
	a_msb: assert property (p_msb)
		else $error("input bit not shifted in at rise");
	property p_drive;
		fall_e && outp |=> miso_o == $past(s.tx[7]);
	endproperty
	a_drive: assert property (p_drive)
		else $error("output bit not taken at fall");
	property p_bp;
		cs_rise && !s2_r.wp_n |=> $stable(bp_o);
	endproperty
	a_bp: assert property (p_bp)
		else $error("protect range changed while protected");
	property p_invalid;
		s_cmd_byte ##0 !known(byte_in) |=> s.ph == PH_IGN && miso_oe_n_o;
	endproperty
	a_invalid: assert property (p_invalid)
		else $error("unknown code not ignored");
	property p_first_rd;
		s_addr_done |=> mem_rd_o ##2 s.tx == $past(mem_rdata_i);
	endproperty
	a_first_rd: assert property (p_first_rd)
		else $error("read data not loaded after address");
	property p_busy;
		mem_commit_o |=> busy_o [*8];
	endproperty
	a_busy: assert property (p_busy)
		else $error("busy dropped right after commit");
	property p_page;
		push_v |=> s.addr[15:7] == $past(s.addr[15:7]);
	endproperty
	a_page: assert property (p_page)
		else $error("write address left its page");
endmodule

// file: seb_master.sv
`timescale 1ns/10ps
module seb_master (
	input  wire logic clk_i,
	input  wire logic miso_i,
	input  wire logic oe_n_i,
	output logic      sck_o,
	output logic      cs_n_o,
	output logic      mosi_o,
	output logic      hold_n_o
);
	logic        cpol;
	logic [31:0] rx;
	// select starts low so the first command after reset sees no select fall
	initial
	begin
		cpol = 1'b0;
		rx = '0;
		sck_o = 1'b0;
		cs_n_o = 1'b0;
		mosi_o = 1'b0;
		hold_n_o = 1'b1;
	end
	// half of an 80 ns link period, always ending on a falling clk edge
	task automatic half();
		repeat (5) @(negedge clk_i);
	endtask
	task automatic sel();
		sck_o = cpol;
		half();
		cs_n_o = 1'b0;
		half();
	endtask
	// a released line shows the inverse of the last bit, so stale data never matches
	task automatic shift(input int n, input logic [31:0] d);
		for (int i = n - 1; i >= 0; i--)
		begin
			sck_o = 1'b0;
			mosi_o = d[i];
			half();
			sck_o = 1'b1;
			rx = {rx[30:0], oe_n_i ? ~rx[0] : miso_i};
			half();
		end
	endtask
	task automatic desel();
		sck_o = cpol;
		half();
		cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
		half();
		half();
	endtask
	// clock and data wiggle while paused to show they are ignored
	task automatic pause();
		sck_o = 1'b0;
		half();
		hold_n_o = 1'b0;
		half();
		sck_o = 1'b1;
		mosi_o = ~mosi_o;
		half();
		sck_o = 1'b0;
		half();
	endtask
	task automatic resume();
		hold_n_o = 1'b1;
		half();
	endtask
endmodule

// file: testbench.sv
`timescale 1ns/10ps
module testbench;
	import seb_pkg::*;
	logic        clk_i;
	logic        rst_i;
	logic        sck;
	logic        cs_n;
	logic        mosi;
	logic        hold_n;
	logic        wp_n_i;
	logic        miso_o;
	logic        miso_oe_n_o;
	logic [15:0] mem_addr_o;
	logic        mem_rd_o;
	logic [7:0]  mem_rdata_i;
	logic        mem_we_o;
	logic [7:0]  mem_wdata_o;
	logic        mem_wr_ready_i;
	logic        mem_commit_o;
	logic        mem_abort_o;
	logic        busy_o;
	logic        wel_o;
	logic [1:0]  bp_o;
	logic        standby_o;
	logic        overrun_o;
	logic [23:0] wq[$];
	int          ncom;
	int          nab;
	int          n_mismatch;
	int          checks;

	seb_core #(.WRITE_CYC(50)) uut (
		.clk_i(clk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi),
		.hold_n_i(hold_n), .wp_n_i(wp_n_i), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o),
		.mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_rdata_i(mem_rdata_i),
		.mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o), .mem_wr_ready_i(mem_wr_ready_i),
		.mem_commit_o(mem_commit_o), .mem_abort_o(mem_abort_o), .busy_o(busy_o),
		.wel_o(wel_o), .bp_o(bp_o), .standby_o(standby_o), .overrun_o(overrun_o)
	);
	seb_master m (
		.clk_i(clk_i), .miso_i(miso_o), .oe_n_i(miso_oe_n_o), .sck_o(sck),
		.cs_n_o(cs_n), .mosi_o(mosi), .hold_n_o(hold_n)
	);

	// array content is a fold of the address, so locations sharing a high byte read differently
	function automatic logic [7:0] arr(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction
	assign mem_rdata_i = arr(mem_addr_o);

	always @(posedge clk_i)
	begin
		if (mem_we_o && mem_wr_ready_i)
			wq.push_back({mem_addr_o, mem_wdata_o});
		if (mem_commit_o)
			ncom++;
		if (mem_abort_o)
			nab++;
	end

	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cmd(input int n, input logic [31:0] d);
		m.sel();
		m.shift(n, d);
		m.desel();
	endtask
	task automatic idle();
		for (int i = 0; i < 500 && busy_o !== 1'b0; i++)
			@(negedge clk_i);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		// several times the expected run, well inside the cycle budget
		#400_000;
		n_mismatch++;
		report_and_stop();
	end

	initial
	begin
		rst_i = 1'b1;
		wp_n_i = 1'b1;
		mem_wr_ready_i = 1'b1;
		ncom = 0;
		nab = 0;
		n_mismatch = 0;
		checks = 0;
		repeat (16) @(negedge clk_i);
		rst_i = 1'b0;
		m.shift(8, CMD_EN_MOD);
		m.desel();
		chk(wel_o, 1'b0);
		chk(standby_o, 1'b1);
		cmd(8, CMD_EN_MOD);
		chk(wel_o, 1'b1);
		m.sel();
		m.shift(16, 32'hff00);
		chk(miso_oe_n_o, 1'b1);
		m.desel();
		chk(wel_o, 1'b1);
		cmd(9, {CMD_DIS_MOD, 1'b0});
		chk(wel_o, 1'b1);
		cmd(8, CMD_DIS_MOD);
		chk(wel_o, 1'b0);
		wp_n_i = 1'b0;
		cmd(8, CMD_EN_MOD);
		cmd(16, {CMD_WR_FLAGS, 8'h0c});
		idle();
		chk(bp_o, 2'b00);
		wp_n_i = 1'b1;
		cmd(8, CMD_EN_MOD);
		cmd(16, {CMD_WR_FLAGS, 8'h04});
		idle();
		chk(bp_o, 2'b01);
		m.sel();
		m.shift(16, {CMD_RD_FLAGS, 8'h00});
		m.desel();
		chk(m.rx[7:0], 8'h04);
		wq.delete();
		ncom = 0;
		// three bytes from the top of a page wrap back to its start
		cmd(8, CMD_EN_MOD);
		m.sel();
		m.shift(24, {CMD_WR_ARR, 16'h107e});
		m.shift(24, 24'ha53cf0);
		m.desel();
		chk(busy_o, 1'b1);
		chk(standby_o, 1'b0);
		idle();
		chk(wq.size(), 3);
		chk(wq[0], 24'h107ea5);
		chk(wq[2], 24'h1000f0);
		chk(ncom, 1);
		chk(wel_o, 1'b0);
		m.cpol = 1'b1;
		m.sel();
		m.shift(24, {CMD_RD_ARR, 16'h10ff});
		m.shift(16, 32'h0);
		m.desel();
		chk(m.rx[15:0], {arr(16'h10ff), arr(16'h1100)});
		m.cpol = 1'b0;
		m.sel();
		m.shift(24, {CMD_RD_ARR, 16'h0020});
		m.shift(8, 32'h0);
		chk(m.rx[7:0], arr(16'h0020));
		m.pause();
		chk(miso_oe_n_o, 1'b1);
		m.resume();
		m.shift(8, 32'h0);
		chk(m.rx[7:0], arr(16'h0021));
		m.desel();
		// upper quarter is protected: the byte is dropped, the cycle still runs
		wq.delete();
		ncom = 0;
		cmd(8, CMD_EN_MOD);
		m.sel();
		m.shift(24, {CMD_WR_ARR, 16'hc000});
		m.shift(8, 8'h77);
		m.desel();
		idle();
		chk(wq.size(), 0);
		chk(ncom, 1);
		// a ragged last byte discards the page latch and keeps the enable
		cmd(8, CMD_EN_MOD);
		m.sel();
		m.shift(24, {CMD_WR_ARR, 16'h0040});
		m.shift(12, 12'h5a5);
		m.desel();
		chk(nab, 1);
		chk(busy_o, 1'b0);
		chk(wel_o, 1'b1);
		// stalled array: one byte waits in the write stage, sixteen fill the buffer,
		// so the eighteenth byte is the one lost
		mem_wr_ready_i = 1'b0;
		cmd(8, CMD_EN_MOD);
		m.sel();
		m.shift(24, {CMD_WR_ARR, 16'h0000});
		for (int i = 0; i < 18; i++)
			m.shift(8, i);
		chk(overrun_o, 1'b1);
		mem_wr_ready_i = 1'b1;
		m.desel();
		idle();
		m.sel();
		chk(overrun_o, 1'b0);
		m.shift(8, CMD_DIS_MOD);
		m.desel();
		chk(standby_o, 1'b1);
		report_and_stop();
	end
endmodule
